/* File: cfg_handshake.sv */
// Carries the configuration word from the system clock into the link clock.
// Assumes both resets are already synchronous to their own clocks.
`timescale 1ns/1ps
`default_nettype none

module cfg_handshake
  import serial_rx_pkg::*;
(
  // System side
  input  wire logic      clk_i,
  input  wire logic      rst_i,
  input  wire cfg_word_t src_word_i,
  output logic           busy_o,
  // Link side
  input  wire logic      link_clk_i,
  input  wire logic      link_rst_i,
  output cfg_word_t      dst_word_o
);

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  typedef struct packed {
    cfg_word_t held;      // Word in flight, stable until acknowledged
    logic      req;       // Request toggle
    logic      ack_meta;  // Acknowledge synchroniser, first stage
    logic      ack_sync;  // Acknowledge synchroniser, second stage
  } src_state_t;

  typedef struct packed {
    cfg_word_t word;      // Applied word
    logic      req_meta;  // Request synchroniser, first stage
    logic      req_sync;  // Request synchroniser, second stage
    logic      ack;       // Acknowledge toggle
  } dst_state_t;

  src_state_t s_q, s_d;  // System-side state
  dst_state_t t_q, t_d;  // Link-side state

  // Launch a new word only when idle and the source has moved on
  always_comb begin
    s_d          = s_q;
    s_d.ack_meta = t_q.ack;
    s_d.ack_sync = s_q.ack_meta;
    if ((s_q.req == s_q.ack_sync) && (src_word_i != s_q.held)) begin
      s_d.held = src_word_i;
      s_d.req  = ~s_q.req;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '{held: RST_CFG_WORD, req: 1'b0, ack_meta: 1'b0, ack_sync: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  // Capture the held word once the request toggle has settled
  always_comb begin
    t_d          = t_q;
    t_d.req_meta = s_q.req;
    t_d.req_sync = t_q.req_meta;
    if (t_q.req_sync != t_q.ack) begin
      t_d.word = s_q.held;
      t_d.ack  = t_q.req_sync;
    end
  end

  always_ff @(posedge link_clk_i) begin
    if (link_rst_i) begin
      t_q <= '{word: RST_CFG_WORD, req_meta: 1'b0, req_sync: 1'b0, ack: 1'b0};
    end else begin
      t_q <= t_d;
    end
  end

  assign busy_o     = (s_q.req != s_q.ack_sync);
  assign dst_word_o = t_q.word;

endmodule

`default_nettype wire

/* File: host_model.sv */
// Host that takes synchronous serial bits off the pins.
// Assumes the bit clock and data lines already resolved from their enables.
`timescale 1ns/1ps
`default_nettype none
module host_model (
  // Pin lines and capture enable
  input wire logic bclk_i,
  input wire logic data_i,
  input wire logic en_i
);
  logic rx_q [0:63];  // Raw bits, no preamble or sync search
  int   cnt_q = 0;    // Bits taken so far
  // Sample on the stable rising edge; framing is left to software
  always @(posedge bclk_i) begin
    if (en_i && cnt_q < 64) begin
      rx_q[cnt_q] <= data_i;
      cnt_q <= cnt_q + 1;
    end
  end
endmodule
`default_nettype wire

/* File: serial_rx_output.sv */
// Receive data output path for the serial modes: register file, mode
// selection, bit recovery and routing to three general-purpose pins.
// Assumes a classic Wishbone master on clk_i and a demodulator whose raw
// level is produced on link_clk_i.
//
// Contract
// - Format value 3 selects asynchronous serial mode
// - Asynchronous mode bypasses packet handling and Manchester
// - Data goes to pins selecting data function
// - Asynchronous: raw demodulated level, no bit decision
// - Asynchronous output updated at eight samples per bit
// - Asynchronous output may glitch one oscillator period
// - Synchronous mode uses data plus clock lines
// - Device drives the bit clock on a pin
// - Synchronous data leaves nine bit periods later
//
// Design decisions made here: the register offsets and the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none

module serial_rx_output
  import serial_rx_pkg::*;
(
  // System clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic [31:0] adr_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  input  wire logic        we_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  output logic             ack_o,
  // Packet handler control
  output logic             packet_bypass_o,
  output logic             manchester_allowed_o,
  // Link clock and demodulator
  input  wire logic        link_clk_i,
  input  wire logic        demod_level_i,
  // General-purpose output pins
  output logic             general_output_zero_o,
  output logic             general_output_zero_oe_o,
  output logic             general_output_one_o,
  output logic             general_output_one_oe_o,
  output logic             general_output_two_o,
  output logic             general_output_two_oe_o
);

  // ---------------------------------------------------------------------------
  // Helper functions
  // ---------------------------------------------------------------------------
  // Drive one pin from its signal select
  function automatic logic [1:0] pin_drive(input logic [5:0] sel,
                                           input mode_t      mode,
                                           input logic       data,
                                           input logic       bclk);
    logic serial;
    serial = (mode != MODE_PACKET);
    if (sel == SEL_HIGH_Z) begin
      return 2'b00;                       // Released, level low
    end else if (sel == SEL_SERIAL_DATA) begin
      return {data & serial, 1'b1};
    end else if (sel == SEL_SERIAL_CLOCK) begin
      return {bclk & (mode == MODE_SYNC), 1'b1};
    end
    return 2'b01;                         // Other functions drive low here
  endfunction

  // ---------------------------------------------------------------------------
  // System-domain state
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  pin_two_config;        // Pin two configuration
    logic [7:0]  pin_one_config;        // Pin one configuration
    logic [7:0]  pin_zero_config;       // Pin zero configuration
    logic [7:0]  packet_control_b;      // Packet control
    logic [7:0]  modem_config_c;        // Modem configuration
    logic [7:0]  sample_divider;        // Link clocks per sample, minus one
    logic        ack;                   // Bus acknowledge
    logic [31:0] rdata;                 // Read data
    logic        bypass;                // Packet handler bypassed
    logic [2:0]  mode_meta;             // Applied mode, first stage
    logic [2:0]  mode_sync;             // Applied mode, second stage
    logic [2:0]  pin_meta;              // Pin levels, first stage
    logic [2:0]  pin_sync;              // Pin levels, second stage
  } sys_state_t;

  // ---------------------------------------------------------------------------
  // Link-domain state
  // ---------------------------------------------------------------------------
  typedef struct packed {
    mode_t                   mode;      // Applied serial mode
    logic [7:0]              div_cnt;   // Sample divider count
    logic [2:0]              smp_idx;   // Sample index within a bit
    logic [3:0]              ones;      // Ones seen in the current bit
    logic [LATENCY_BITS-1:0] hist;      // Decided bits awaiting output
    logic                    data;      // Data line value
    logic                    bclk;      // Bit clock value
    pins_t                   pins;      // Registered pin drive
  } link_state_t;

  sys_state_t  s_q, s_d;       // System state
  link_state_t l_q, l_d;       // Link state
  logic        lrst_meta;      // Link reset, first stage
  logic        lrst;           // Link reset, synchronous to link clock
  cfg_word_t   cfg_src;        // Configuration as written
  cfg_word_t   cfg_link;       // Configuration as applied
  logic        cfg_busy;       // Transfer pending
  logic [7:0]  word_idx;       // Register index on the bus
  logic        idx_ok;         // Address within the decoded window
  logic        wr_en;          // Write strobe for the low byte

  // ---------------------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------------------
  assign word_idx = adr_i[9:2];
  assign idx_ok   = (adr_i[31:10] == 22'h000000) && (adr_i[1:0] == 2'h0);
  assign wr_en    = cyc_i & stb_i & ~s_q.ack & we_i & sel_i[0] & idx_ok;

  // Register file, status synchronisers and read mux
  always_comb begin
    s_d           = s_q;
    s_d.ack       = cyc_i & stb_i & ~s_q.ack;   // One wait state, then ack
    s_d.mode_meta = l_q.mode;
    s_d.mode_sync = s_q.mode_meta;
    s_d.pin_meta  = l_q.pins.level;
    s_d.pin_sync  = s_q.pin_meta;
    // Write side, low byte only
    if (wr_en) begin
      case (word_idx)
        IDX_PIN_TWO_CONFIG:  s_d.pin_two_config   = dat_i[7:0];
        IDX_PIN_ONE_CONFIG:  s_d.pin_one_config   = dat_i[7:0];
        IDX_PIN_ZERO_CONFIG: s_d.pin_zero_config  = dat_i[7:0];
        IDX_PACKET_CONTROL:  s_d.packet_control_b = dat_i[7:0];
        IDX_MODEM_CONFIG:    s_d.modem_config_c   = dat_i[7:0];
        IDX_SAMPLE_DIVIDER:  s_d.sample_divider   = dat_i[7:0];
        default:             s_d.ack              = s_d.ack;  // Unmapped: ignored
      endcase
    end
    // Read side; unmapped reads as zero
    s_d.rdata = 32'h00000000;
    if (cyc_i & stb_i & ~s_q.ack & ~we_i & idx_ok) begin
      case (word_idx)
        IDX_PIN_TWO_CONFIG:  s_d.rdata[7:0] = s_q.pin_two_config;
        IDX_PIN_ONE_CONFIG:  s_d.rdata[7:0] = s_q.pin_one_config;
        IDX_PIN_ZERO_CONFIG: s_d.rdata[7:0] = s_q.pin_zero_config;
        IDX_PACKET_CONTROL:  s_d.rdata[7:0] = s_q.packet_control_b;
        IDX_MODEM_CONFIG:    s_d.rdata[7:0] = s_q.modem_config_c;
        IDX_SAMPLE_DIVIDER:  s_d.rdata[7:0] = s_q.sample_divider;
        IDX_STATUS: begin
          s_d.rdata[ST_MODE_LSB +: 3] = s_q.mode_sync;
          s_d.rdata[ST_PIN_LSB +: 3]  = s_q.pin_sync;
          s_d.rdata[ST_BUSY_BIT]      = cfg_busy;
        end
        default:             s_d.rdata = 32'h00000000;
      endcase
    end
    // Asynchronous mode turns packet handling off
    s_d.bypass = (format_to_mode(s_d.packet_control_b[FORMAT_LSB +: 2]) == MODE_ASYNC);
  end

  // System register stage
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '{pin_two_config:   RST_PIN_CONFIG,
               pin_one_config:   RST_PIN_CONFIG,
               pin_zero_config:  RST_PIN_CONFIG,
               packet_control_b: RST_PACKET_CONTROL,
               modem_config_c:   RST_MODEM_CONFIG,
               sample_divider:   RST_SAMPLE_DIVIDER,
               ack:              1'b0,
               rdata:            32'h00000000,
               bypass:           1'b0,
               mode_meta:        3'h0,
               mode_sync:        3'h0,
               pin_meta:         3'h0,
               pin_sync:         3'h0};
    end else begin
      s_q <= s_d;
    end
  end

  assign ack_o                = s_q.ack;
  assign dat_o                = s_q.rdata;
  assign packet_bypass_o      = s_q.bypass;
  assign manchester_allowed_o = ~s_q.bypass;

  // ---------------------------------------------------------------------------
  // Configuration crossing
  // ---------------------------------------------------------------------------
  assign cfg_src = '{sel_two:  s_q.pin_two_config[SIGSEL_LSB +: 6],
                     sel_one:  s_q.pin_one_config[SIGSEL_LSB +: 6],
                     sel_zero: s_q.pin_zero_config[SIGSEL_LSB +: 6],
                     format:   s_q.packet_control_b[FORMAT_LSB +: 2],
                     divider:  s_q.sample_divider};

  // Reset is brought into the link domain before use
  always_ff @(posedge link_clk_i) begin
    lrst_meta <= rst_i;
    lrst      <= lrst_meta;
  end

  cfg_handshake u_cfg (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .src_word_i (cfg_src),
    .busy_o     (cfg_busy),
    .link_clk_i (link_clk_i),
    .link_rst_i (lrst),
    .dst_word_o (cfg_link)
  );

  // ---------------------------------------------------------------------------
  // Link-side bit recovery and pin drive
  // ---------------------------------------------------------------------------
  always_comb begin
    logic       tick;     // One sample period elapsed
    logic [3:0] ones_n;   // Ones including this sample
    logic [1:0] drv_two;  // Pin two drive
    logic [1:0] drv_one;  // Pin one drive
    logic [1:0] drv_zero; // Pin zero drive
    tick     = 1'b0;
    ones_n   = 4'h0;
    drv_two  = 2'b00;
    drv_one  = 2'b00;
    drv_zero = 2'b00;
    l_d      = l_q;
    l_d.mode = format_to_mode(cfg_link.format);
    // Sample divider
    if (l_q.div_cnt >= cfg_link.divider) begin
      l_d.div_cnt = 8'h00;
      tick        = 1'b1;
    end else begin
      l_d.div_cnt = l_q.div_cnt + 8'h01;
    end
    ones_n = l_q.ones + {3'h0, demod_level_i};
    if (l_d.mode != l_q.mode) begin
      // Mode change restarts bit timing and drops stale bits
      l_d.smp_idx = 3'h0;
      l_d.ones    = 4'h0;
      l_d.hist    = '0;
      l_d.data    = 1'b0;
      l_d.bclk    = 1'b0;
    end else if (tick) begin
      case (l_q.mode)
        MODE_ASYNC: begin
          // Raw level, refreshed once per sample, no decision
          l_d.data = demod_level_i;
        end
        MODE_SYNC: begin
          l_d.smp_idx = l_q.smp_idx + 3'h1;
          l_d.ones    = ones_n;
          if (l_q.smp_idx == CLOCK_RISE_IDX) begin
            l_d.bclk = 1'b1;
          end
          if (l_q.smp_idx == SAMPLE_LAST) begin
            // Majority decision, then nine-bit delay
            l_d.hist = {l_q.hist[LATENCY_BITS-2:0], (ones_n >= MAJORITY)};
            l_d.data = l_q.hist[LATENCY_BITS-1];
            l_d.bclk = 1'b0;
            l_d.ones = 4'h0;
          end
        end
        default: begin
          // Packet mode: serial lines idle low
          l_d.data = 1'b0;
          l_d.bclk = 1'b0;
        end
      endcase
    end
    // Route to pins by signal select
    drv_two       = pin_drive(cfg_link.sel_two, l_d.mode, l_d.data, l_d.bclk);
    drv_one       = pin_drive(cfg_link.sel_one, l_d.mode, l_d.data, l_d.bclk);
    drv_zero      = pin_drive(cfg_link.sel_zero, l_d.mode, l_d.data, l_d.bclk);
    l_d.pins.level = {drv_two[1], drv_one[1], drv_zero[1]};
    l_d.pins.oe    = {drv_two[0], drv_one[0], drv_zero[0]};
  end

  // Link register stage
  always_ff @(posedge link_clk_i) begin
    if (lrst) begin
      l_q <= '{mode:    MODE_PACKET,
               div_cnt: 8'h00,
               smp_idx: 3'h0,
               ones:    4'h0,
               hist:    '0,
               data:    1'b0,
               bclk:    1'b0,
               pins:    '{level: 3'h0, oe: 3'h0}};
    end else begin
      l_q <= l_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Pin outputs
  // ---------------------------------------------------------------------------
  assign general_output_zero_o    = l_q.pins.level[0];
  assign general_output_zero_oe_o = l_q.pins.oe[0];
  assign general_output_one_o     = l_q.pins.level[1];
  assign general_output_one_oe_o  = l_q.pins.oe[1];
  assign general_output_two_o     = l_q.pins.level[2];
  assign general_output_two_oe_o  = l_q.pins.oe[2];

endmodule

`default_nettype wire

/* File: serial_rx_pkg.sv */
// Shared constants, types and helpers for the serial receive data output path.
// Assumes a Wishbone slave on the system clock and a demodulator on a link clock.
package serial_rx_pkg;

  // ---------------------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ---------------------------------------------------------------------------
  localparam logic [7:0] IDX_PIN_TWO_CONFIG  = 8'h00;  // Pin two configuration
  localparam logic [7:0] IDX_PIN_ONE_CONFIG  = 8'h01;  // Pin one configuration
  localparam logic [7:0] IDX_PIN_ZERO_CONFIG = 8'h02;  // Pin zero configuration
  localparam logic [7:0] IDX_PACKET_CONTROL  = 8'h08;  // Packet automation control
  localparam logic [7:0] IDX_MODEM_CONFIG    = 8'h12;  // Modem configuration
  localparam logic [7:0] IDX_SAMPLE_DIVIDER  = 8'h40;  // Link clocks per sample, minus one
  localparam logic [7:0] IDX_STATUS          = 8'h41;  // Read-only path status

  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int SIGSEL_LSB  = 0;  // Pin signal select [5:0]
  localparam int FORMAT_LSB  = 4;  // packet_format_select [5:4]
  localparam int CRC_EN_BIT  = 2;  // Checksum enable
  localparam int LENGTH_LSB  = 0;  // Packet length selection [1:0]
  localparam int SYNCQ_LSB   = 0;  // Sync-word qualifier [2:0]
  localparam int ST_MODE_LSB = 0;  // Status: applied mode, one-hot [2:0]
  localparam int ST_PIN_LSB  = 4;  // Status: pin levels [6:4]
  localparam int ST_BUSY_BIT = 8;  // Status: configuration transfer pending

  // ---------------------------------------------------------------------------
  // Values after reset
  // ---------------------------------------------------------------------------
  localparam logic [7:0] RST_PIN_CONFIG     = 8'h2F;
  localparam logic [7:0] RST_PACKET_CONTROL = 8'h00;
  localparam logic [7:0] RST_MODEM_CONFIG   = 8'h00;
  localparam logic [7:0] RST_SAMPLE_DIVIDER = 8'h03;

  // ---------------------------------------------------------------------------
  // Codes
  // ---------------------------------------------------------------------------
  localparam logic [5:0] SEL_SERIAL_CLOCK = 6'h0B;  // Bit clock on pin
  localparam logic [5:0] SEL_SERIAL_DATA  = 6'h0C;  // Receive data on pin
  localparam logic [5:0] SEL_HIGH_Z       = 6'h2E;  // Pin released
  localparam logic [1:0] FMT_SYNC_SERIAL  = 2'h1;
  localparam logic [1:0] FMT_ASYNC_SERIAL = 2'h3;

  // ---------------------------------------------------------------------------
  // Cycle counts
  // ---------------------------------------------------------------------------
  localparam logic [2:0] SAMPLE_LAST    = 3'h7;  // 8 samples per bit
  localparam logic [2:0] CLOCK_RISE_IDX = 3'h3;  // Bit clock rises mid-bit
  localparam logic [3:0] MAJORITY       = 4'h4;  // Ones needed for a one
  localparam int         LATENCY_BITS   = 9;     // Bits held before output

  // ---------------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_PACKET = 3'b001,
    MODE_SYNC   = 3'b010,
    MODE_ASYNC  = 3'b100
  } mode_t;

  typedef struct packed {
    logic [5:0] sel_two;   // Pin two signal select
    logic [5:0] sel_one;   // Pin one signal select
    logic [5:0] sel_zero;  // Pin zero signal select
    logic [1:0] format;    // Packet format select
    logic [7:0] divider;   // Link clocks per sample, minus one
  } cfg_word_t;

  typedef struct packed {
    logic [2:0] level;  // Pin output levels, index 2 is pin two
    logic [2:0] oe;     // Pin output enables
  } pins_t;

  localparam cfg_word_t RST_CFG_WORD = '{
    sel_two:  RST_PIN_CONFIG[5:0],
    sel_one:  RST_PIN_CONFIG[5:0],
    sel_zero: RST_PIN_CONFIG[5:0],
    format:   RST_PACKET_CONTROL[5:4],
    divider:  RST_SAMPLE_DIVIDER
  };

  // Format field to one-hot mode
  function automatic mode_t format_to_mode(input logic [1:0] fmt);
    if (fmt == FMT_ASYNC_SERIAL) begin
      return MODE_ASYNC;
    end else if (fmt == FMT_SYNC_SERIAL) begin
      return MODE_SYNC;
    end
    return MODE_PACKET;
  endfunction

endpackage

/* File: serial_rx_sva.sv */
// Checker for the serial receive output path.
// Sees only the top module's ports; bound at the foot of this file.
`timescale 1ns/1ps
`default_nettype none
module serial_rx_sva
  import serial_rx_pkg::*;
(
  // Clocks and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        link_clk_i,
  // Bus
  input wire logic [31:0] adr_i,
  input wire logic [31:0] dat_i,
  input wire logic        we_i,
  input wire logic [3:0]  sel_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        ack_o,
  // Mode and pins
  input wire logic        packet_bypass_o,
  input wire logic        manchester_allowed_o,
  input wire logic        demod_level_i,
  input wire logic        general_output_zero_o,
  input wire logic        general_output_one_o,
  input wire logic        general_output_one_oe_o,
  input wire logic        general_output_two_oe_o
);
  // ----
  // Configuration as seen on the bus
  // ----
  logic [5:0] s0_q, s1_q, s2_q;  // Pin selects
  logic [1:0] fmt_q;             // Format field
  logic [7:0] div_q;             // Sample divider
  logic [3:0] quiet_q;           // Cycles since the last write
  logic       wr, ok, sy;
  assign wr = cyc_i && stb_i && we_i && ack_o && sel_i[0] && adr_i[31:10] == '0
              && adr_i[1:0] == 2'h0;
  assign ok = quiet_q == 4'hF && div_q == 8'h00;
  assign sy = ok && fmt_q == FMT_SYNC_SERIAL && s1_q == SEL_SERIAL_CLOCK;
  // Follow every accepted write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      {s0_q, s1_q, s2_q} <= {3{RST_PIN_CONFIG[5:0]}};
      fmt_q <= RST_PACKET_CONTROL[5:4];
      div_q <= RST_SAMPLE_DIVIDER;
      quiet_q <= 4'h0;
    end else begin
      if (wr && adr_i[9:2] == IDX_PIN_ZERO_CONFIG) s0_q <= dat_i[5:0];
      if (wr && adr_i[9:2] == IDX_PIN_ONE_CONFIG) s1_q <= dat_i[5:0];
      if (wr && adr_i[9:2] == IDX_PIN_TWO_CONFIG) s2_q <= dat_i[5:0];
      if (wr && adr_i[9:2] == IDX_PACKET_CONTROL) fmt_q <= dat_i[5:4];
      if (wr && adr_i[9:2] == IDX_SAMPLE_DIVIDER) div_q <= dat_i[7:0];
      quiet_q <= wr ? 4'h0 : (quiet_q == 4'hF ? quiet_q : quiet_q + 4'h1);
    end
  end
  // Bit clock high for four samples, then low
  sequence clk_high4;
    (general_output_one_o || !sy) [*4];
  endsequence
  sequence clk_then_low;
    clk_high4 ##1 (!general_output_one_o || !sy);
  endsequence
  // ----
  // Assertions
  // ----
  AST_ACK_PULSE: assert property (@(posedge clk_i) disable iff (rst_i)
    cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o) else $error("ack not one cycle");
  AST_BYPASS_ON: assert property (@(posedge clk_i) disable iff (rst_i)
    wr && adr_i[9:2] == IDX_PACKET_CONTROL && dat_i[5:4] == FMT_ASYNC_SERIAL
    |=> ##[0:2] packet_bypass_o) else $error("bypass not set");
  AST_BYPASS_OFF: assert property (@(posedge clk_i) disable iff (rst_i)
    wr && adr_i[9:2] == IDX_PACKET_CONTROL && dat_i[5:4] != FMT_ASYNC_SERIAL
    |=> ##[0:2] !packet_bypass_o) else $error("bypass not cleared");
  AST_MANCH: assert property (@(posedge clk_i) disable iff (rst_i)
    manchester_allowed_o == !packet_bypass_o) else $error("manchester flag wrong");
  AST_HIGHZ_OE: assert property (@(posedge link_clk_i) disable iff (rst_i)
    ok && s2_q == SEL_HIGH_Z |-> !general_output_two_oe_o) else $error("released pin driven");
  AST_CLK_OE: assert property (@(posedge link_clk_i) disable iff (rst_i)
    sy |-> general_output_one_oe_o) else $error("bit clock pin not driven");
  AST_CLK_SHAPE: assert property (@(posedge link_clk_i) disable iff (rst_i)
    sy && $rose(general_output_one_o) |-> clk_then_low) else $error("bit clock shape");
  AST_DATA_EDGE: assert property (@(posedge link_clk_i) disable iff (rst_i)
    sy && s0_q == SEL_SERIAL_DATA && $changed(general_output_zero_o)
    |-> $fell(general_output_one_o)) else $error("data moved off falling edge");
  AST_ASYNC_RAW: assert property (@(posedge link_clk_i) disable iff (rst_i)
    ok && fmt_q == FMT_ASYNC_SERIAL && s0_q == SEL_SERIAL_DATA
    && $changed(general_output_zero_o) |-> $past(demod_level_i, 1) != $past(demod_level_i, 2)
    || $past(demod_level_i, 2) != $past(demod_level_i, 3)) else $error("async data not raw");
  AST_PACKET_ZERO: assert property (@(posedge link_clk_i) disable iff (rst_i)
    ok && fmt_q[0] == 1'b0 && s0_q == SEL_SERIAL_DATA |-> !general_output_zero_o)
    else $error("data pin active in packet mode");
endmodule
bind serial_rx_output serial_rx_sva chk (.clk_i, .rst_i, .link_clk_i, .adr_i, .dat_i, .we_i,
  .sel_i, .cyc_i, .stb_i, .ack_o, .packet_bypass_o, .manchester_allowed_o, .demod_level_i,
  .general_output_zero_o, .general_output_one_o, .general_output_one_oe_o,
  .general_output_two_oe_o);
`default_nettype wire

/* File: tb.sv */
// Testbench: register cycles on the bus, then sync, async and packet runs.
// Assumes the checker is bound by its own file.
`timescale 1ns/1ps
`default_nettype none
module tb
  import serial_rx_pkg::*;
;
  logic        clk_i = 1'b0, link_clk_i = 1'b0, rst_i = 1'b1;
  logic        cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, demod = 1'b0, en = 1'b0;
  logic [31:0] adr_i = '0, dat_i = '0, dat_o, r;
  logic [3:0]  sel_i = 4'h0;
  logic        ack_o, byp, man, p0, p0e, p1, p1e, p2, p2e, bclk_w, data_w;
  logic [23:0] pat = 24'hB4D265;  // Bits sent in sync mode
  int          num_errors = 0, n_tests = 0;
  always #4 clk_i = ~clk_i;
  always #3 link_clk_i = ~link_clk_i;
  assign bclk_w = p1e ? p1 : 1'bz;
  assign data_w = p0e ? p0 : 1'bz;
  serial_rx_output uut (.clk_i, .rst_i, .adr_i, .dat_i, .dat_o, .we_i, .sel_i, .cyc_i,
    .stb_i, .ack_o, .packet_bypass_o(byp), .manchester_allowed_o(man), .link_clk_i,
    .demod_level_i(demod), .general_output_zero_o(p0), .general_output_zero_oe_o(p0e),
    .general_output_one_o(p1), .general_output_one_oe_o(p1e),
    .general_output_two_o(p2), .general_output_two_oe_o(p2e));
  host_model hm (.bclk_i(bclk_w), .data_i(data_w), .en_i(en));
  // Verdict and end of run
  task end_sim;
    $display("errors %0d of %0d checks", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Compare one value
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One classic bus cycle; read data lands in r
  task wb(input logic w, input logic [7:0] i, input logic [7:0] d);
    int n;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    sel_i <= 4'hF;
    adr_i <= {22'h0, i, 2'h0};
    dat_i <= {24'h0, d};
    n = 0;
    do begin @(posedge clk_i); n++; end while (ack_o !== 1'b1 && n < 20);
    r = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
    if (n >= 20) begin num_errors++; end_sim(); end
  endtask
  // Poll status until the mode is applied
  task mode(input logic [2:0] m);
    int n;
    n = 0;
    do begin wb(1'b0, IDX_STATUS, 8'h00); n++; end while ((r[8] !== 1'b0 || r[2:0] !== m) && n < 30);
    chk(32'(r[2:0]), 32'(m));
    if (r[8] !== 1'b0 || r[2:0] !== m) begin num_errors++; end_sim(); end
  endtask
  // Wait for a falling bit clock
  task fall;
    int   n;
    logic b;
    n = 0;
    do begin b = p1; @(posedge link_clk_i); n++; end while (!(b === 1'b1 && p1 === 1'b0) && n < 40);
    if (n >= 40) begin num_errors++; end_sim(); end
  endtask
  // ----
  // Main sequence
  // ----
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, IDX_PIN_TWO_CONFIG, 8'h00); chk(r, 32'h0000002F);
    wb(1'b0, IDX_SAMPLE_DIVIDER, 8'h00); chk(r, 32'h00000003);
    wb(1'b1, 8'h3C, 8'hFF); wb(1'b0, 8'h3C, 8'h00); chk(r, 32'h0);
    wb(1'b1, IDX_SAMPLE_DIVIDER, 8'h00);
    wb(1'b1, IDX_PIN_TWO_CONFIG, {2'h0, SEL_HIGH_Z});
    wb(1'b1, IDX_PIN_ONE_CONFIG, {2'h0, SEL_SERIAL_CLOCK});
    wb(1'b1, IDX_PIN_ZERO_CONFIG, {2'h0, SEL_SERIAL_DATA});
    wb(1'b1, IDX_MODEM_CONFIG, 8'h00);
    wb(1'b1, IDX_PACKET_CONTROL, 8'h12);
    mode(MODE_SYNC);
    chk(32'({byp, p2, p2e, p1e, p0e}), 32'h3);
    for (int p = 0; p < 24; p++) begin
      fall();
      demod <= pat[p];
      en <= 1'b1;
    end
    fall();
    for (int q = 0; q < 24; q++) chk(32'(hm.rx_q[q]), q < 10 ? 32'h0 : 32'(pat[q - 10]));
    wb(1'b1, IDX_PACKET_CONTROL, 8'h30);
    mode(MODE_ASYNC);
    chk(32'({byp, man, p1}), 32'h4);
    for (int k = 0; k < 2; k++) begin
      @(posedge link_clk_i);
      demod <= ~demod;
      repeat (8) @(posedge link_clk_i);
      chk(32'(p0), 32'(demod));
    end
    wb(1'b1, IDX_PACKET_CONTROL, 8'h00);
    mode(MODE_PACKET);
    @(posedge link_clk_i);
    demod <= 1'b1;
    repeat (24) @(posedge link_clk_i);
    chk(32'({p0, man}), 32'h1);
    end_sim();
  end
endmodule
`default_nettype wire
